// *** hdl/adc_ctrl_consts.svh ***
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH
// register indices on the plain port
`define OFS_CTRL0 4'h0
`define OFS_CTRL1 4'h1
`define OFS_CTRL2 4'h2
`define OFS_RES_HI 4'h3
`define OFS_RES_LO 4'h4
`define OFS_STATUS 4'h5
// control register 0 fields
`define CTRL0_ON_BIT 0
`define CTRL0_GO_BIT 1
`define CTRL0_CHS_LSB 2
// control register 1 fields
`define CTRL1_VREFP_BIT 0
`define CTRL1_VREFN_BIT 1
`define CTRL1_CLKSEL_BIT 2
`define CTRL1_RJUST_BIT 3
// status register fields
`define STAT_DONE_BIT 0
// reset values
`define CTRL0_RST 8'h00
`define CTRL1_RST 8'h00
`define CTRL2_RST 8'hFF
// timing
`define CLK_HZ 20000000
`define TAD_NS 1000
`define TAD_CYC ((`TAD_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define ACQ_TAD 2
`endif

// *** hdl/adc_ctrl_pkg.sv ***
`default_nettype none
package adc_ctrl_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV, ST_DONE} conv_state_t;
  // analog front end control bundle
  typedef struct packed {
    logic sample;
    logic use_vref_pins_pos;
    logic use_vref_pins_neg;
    logic [3:0] channel;
    logic [9:0] dac_code;
  } afe_ctrl_t;
  // register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage
`default_nettype wire

// *** hdl/sar_engine.sv ***
`timescale 1ns/1ps
`default_nettype none
// successive approximation register: one bit decided per step
module sar_engine #(
  parameter int WIDTH = 10
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic start,
  input wire logic abort,
  input wire logic step,
  input wire logic cmp_hi,
  output logic [WIDTH-1:0] code,
  output logic busy,
  output logic done
);
  logic [WIDTH-1:0] code_q;
  logic [WIDTH-1:0] bit_q;
  logic busy_q;
  logic done_q;
  // trial bit walks from msb down; comparator keeps or drops it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      code_q <= '0;
      bit_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= 1'b0;
      if (abort) begin
        busy_q <= 1'b0;
        bit_q <= '0;
      end else if (start) begin
        busy_q <= 1'b1;
        bit_q <= {1'b1, {(WIDTH-1){1'b0}}};
        code_q <= {1'b1, {(WIDTH-1){1'b0}}};
      end else if (busy_q && step) begin
        code_q <= (cmp_hi ? code_q : (code_q & ~bit_q)) | (bit_q >> 1);
        bit_q <= bit_q >> 1;
        if (bit_q[0]) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
  assign code = code_q;
  assign busy = busy_q;
  assign done = done_q;
endmodule
`default_nettype wire

// *** hdl/adc_conversion_control.sv ***
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_consts.svh"
// Functional notes
// - finished result loads result register pair
// - completion clears conversion-in-progress bit one
// - completion sets the conversion done flag
// - reset restores control and status registers, not the result pair
// - reset turns module off, aborts conversion
// - power-on reset leaves result pair untouched
// - software picks supply rails or reference pins
// - conversions continue while device sleeps only on the rc clock
// - each converter pin analog or digital
// - successive approximation on held sample
module adc_conversion_control #(
  parameter int RES_BITS = 10,
  parameter int NUM_CH = 8
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic CE,
  input wire logic POR_EVENT,
  input wire logic SLEEP,
  input wire logic RC_TICK,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic CMP_HI,
  output var adc_ctrl_pkg::afe_ctrl_t AFE,
  output logic [NUM_CH-1:0] PIN_ANALOG_EN,
  output logic BUSY
);
  import adc_ctrl_pkg::*;

  localparam int TAD_CYC = `TAD_CYC;
  localparam int TADW = $clog2(TAD_CYC + 1);

  reg_req_t req;
  conv_state_t state_q;
  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [NUM_CH-1:0] ctrl2_q;
  logic [7:0] res_hi_q;
  logic [7:0] res_lo_q;
  logic done_flag_q;
  logic [TADW-1:0] tad_cnt_q;
  logic [1:0] acq_cnt_q;
  logic rc_s1_q;
  logic rc_s2_q;
  logic rc_s3_q;
  logic sleep_s1_q;
  logic sleep_s2_q;
  logic tick;
  logic sar_start;
  logic sar_done;
  logic sar_busy;
  logic [RES_BITS-1:0] sar_code;
  logic go_set;
  logic conv_abort;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // two-flop synchronisers for internal rc tick and sleep level
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
      sleep_s1_q <= 1'b0;
      sleep_s2_q <= 1'b0;
    end else if (CE) begin
      rc_s1_q <= RC_TICK;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
      sleep_s1_q <= SLEEP;
      sleep_s2_q <= sleep_s1_q;
    end
  end

  // conversion clock: internal rc edges or divided system clock
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      tad_cnt_q <= '0;
    end else if (CE) begin
      if (tad_cnt_q == TADW'(TAD_CYC - 1)) begin
        tad_cnt_q <= '0;
      end else begin
        tad_cnt_q <= tad_cnt_q + 1'b1;
      end
    end
  end

  // in sleep only the rc source keeps ticking
  always_comb begin
    if (ctrl1_q[`CTRL1_CLKSEL_BIT]) begin
      tick = rc_s2_q & ~rc_s3_q;
    end else begin
      tick = (tad_cnt_q == TADW'(TAD_CYC - 1)) & ~sleep_s2_q;
    end
  end

  assign go_set = req.wr && (req.addr == `OFS_CTRL0) && req.wdata[`CTRL0_GO_BIT];
  assign conv_abort = !ctrl0_q[`CTRL0_ON_BIT];

  // sequencer: acquire, then approximate, then publish
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      state_q <= ST_IDLE;
      acq_cnt_q <= '0;
    end else if (CE) begin
      case (state_q)
        ST_IDLE: begin
          if (ctrl0_q[`CTRL0_GO_BIT] && ctrl0_q[`CTRL0_ON_BIT]) begin
            state_q <= ST_ACQ;
            acq_cnt_q <= '0;
          end
        end
        ST_ACQ: begin
          if (conv_abort) begin
            state_q <= ST_IDLE;
          end else if (tick) begin
            if (acq_cnt_q == 2'(`ACQ_TAD - 1)) begin
              state_q <= ST_CONV;
            end else begin
              acq_cnt_q <= acq_cnt_q + 1'b1;
            end
          end
        end
        ST_CONV: begin
          if (conv_abort) begin
            state_q <= ST_IDLE;
          end else if (sar_done) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign sar_start = (state_q == ST_ACQ) && tick && (acq_cnt_q == 2'(`ACQ_TAD - 1)) && !conv_abort;

  // approximation engine runs on the held sample
  sar_engine #(
    .WIDTH(RES_BITS)
  ) u_sar (
    .clk(CLK_SYS),
    .nrst(NRST),
    .ce(CE),
    .start(sar_start),
    .abort(conv_abort),
    .step(tick),
    .cmp_hi(CMP_HI),
    .code(sar_code),
    .busy(sar_busy),
    .done(sar_done)
  );

  // control register 0: enable, go bit, channel select
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ctrl0_q <= `CTRL0_RST;
    end else if (CE) begin
      if (req.wr && req.addr == `OFS_CTRL0) begin
        ctrl0_q <= req.wdata;
        if (!req.wdata[`CTRL0_ON_BIT]) begin
          ctrl0_q[`CTRL0_GO_BIT] <= 1'b0;
        end
      end
      if (state_q == ST_DONE && !go_set) begin
        ctrl0_q[`CTRL0_GO_BIT] <= 1'b0;
      end
    end
  end

  // control registers 1 and 2: references, clock, pin modes
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ctrl1_q <= `CTRL1_RST;
      ctrl2_q <= NUM_CH'(`CTRL2_RST);
    end else if (CE) begin
      if (req.wr && req.addr == `OFS_CTRL1) begin
        ctrl1_q <= req.wdata;
      end
      if (req.wr && req.addr == `OFS_CTRL2) begin
        ctrl2_q <= req.wdata[NUM_CH-1:0];
      end
    end
  end

  // result pair: loaded only on completion, never on reset
  always_ff @(posedge CLK_SYS) begin
    if (CE && NRST && !POR_EVENT && state_q == ST_DONE) begin
      if (ctrl1_q[`CTRL1_RJUST_BIT]) begin
        res_hi_q <= {6'h00, sar_code[9:8]};
        res_lo_q <= sar_code[7:0];
      end else begin
        res_hi_q <= sar_code[9:2];
        res_lo_q <= {sar_code[1:0], 6'h00};
      end
    end
  end

  // done flag: set wins over a software clear in the same cycle
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      done_flag_q <= 1'b0;
    end else if (CE) begin
      if (state_q == ST_DONE) begin
        done_flag_q <= 1'b1;
      end else if (req.wr && req.addr == `OFS_STATUS && req.wdata[`STAT_DONE_BIT]) begin
        done_flag_q <= 1'b0;
      end
    end
  end

  // read mux, answered in the following cycle
  always_comb begin
    rdata_d = 8'h00;
    case (req.addr)
      `OFS_CTRL0: rdata_d = ctrl0_q;
      `OFS_CTRL1: rdata_d = ctrl1_q;
      `OFS_CTRL2: rdata_d = 8'(ctrl2_q);
      `OFS_RES_HI: rdata_d = res_hi_q;
      `OFS_RES_LO: rdata_d = res_lo_q;
      `OFS_STATUS: rdata_d = {7'h00, done_flag_q};
      default: rdata_d = 8'h00;
    endcase
  end

  // read data stand one enabled cycle per read strobe cycle, and hold while clock enable is low
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rdata_q <= 8'h00;
    end else if (CE) begin
      rdata_q <= req.rd ? rdata_d : 8'h00;
    end
  end

  assign RDATA = rdata_q;

  // analog front end drive
  always_comb begin
    AFE.sample = (state_q == ST_ACQ);
    AFE.use_vref_pins_pos = ctrl1_q[`CTRL1_VREFP_BIT];
    AFE.use_vref_pins_neg = ctrl1_q[`CTRL1_VREFN_BIT];
    AFE.channel = ctrl0_q[`CTRL0_CHS_LSB +: 4];
    AFE.dac_code = sar_code;
  end

  assign PIN_ANALOG_EN = ctrl2_q;
  assign BUSY = sar_busy | (state_q != ST_IDLE);

endmodule
`default_nettype wire

// *** verif/adc_conversion_control_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// bus and control-pin relations seen at the converter ports
module adc_conversion_control_chk #(
  parameter int NUM_CH = 8
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic CE,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire adc_ctrl_pkg::afe_ctrl_t AFE,
  input wire logic [NUM_CH-1:0] PIN_ANALOG_EN,
  input wire logic BUSY
);
  import adc_ctrl_pkg::*;
  logic wr_t;
  logic rd_t;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // strobes that the block really takes
  assign wr_t = WR && CE;
  assign rd_t = RD && CE;
  chk_rd_idle: assert property (!$past(rd_t) && $past(CE) |-> RDATA == 8'h00)
    else $error("read data outside read slot");
  chk_rd_frozen: assert property (!$past(CE) |-> $stable(RDATA))
    else $error("read data moved while clock enable low");
  chk_pins_reset: assert property ($rose(NRST) |-> PIN_ANALOG_EN == '1)
    else $error("pin mask not all analog after reset");
  chk_reset_idle: assert property ($rose(NRST) |-> !BUSY)
    else $error("conversion survives reset");
  chk_pins_write: assert property (wr_t && ADDR == 4'h2 |=> PIN_ANALOG_EN == $past(WDATA))
    else $error("pin mask does not follow write");
  chk_pins_hold: assert property (!$past(wr_t && ADDR == 4'h2) |-> $stable(PIN_ANALOG_EN))
    else $error("pin mask changed without write");
  chk_vref_select: assert property (wr_t && ADDR == 4'h1 |=>
    AFE.use_vref_pins_pos == $past(WDATA[0]) && AFE.use_vref_pins_neg == $past(WDATA[1]))
    else $error("reference select wrong");
  chk_go_starts: assert property (wr_t && ADDR == 4'h0 && WDATA[1:0] == 2'b11 && !BUSY
    ##1 CE |=> BUSY)
    else $error("conversion did not start");
  chk_off_aborts: assert property (wr_t && ADDR == 4'h0 && !WDATA[0] ##1 CE |=> !BUSY)
    else $error("switch off did not abort");
  chk_sample_busy: assert property (AFE.sample |-> BUSY && $stable(AFE.dac_code))
    else $error("trial code moved while sampling");
endmodule
bind adc_conversion_control adc_conversion_control_chk #(.NUM_CH(NUM_CH)) chk_i (
  .CLK_SYS(CLK_SYS), .NRST(NRST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .AFE(AFE), .PIN_ANALOG_EN(PIN_ANALOG_EN), .BUSY(BUSY));
`default_nettype wire

// *** verif/analog_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// comparator and sample-and-hold seen from the analog pins
module analog_src_model (
  input wire logic clk,
  input wire adc_ctrl_pkg::afe_ctrl_t afe,
  input wire logic [9:0] v_rail,
  input wire logic [9:0] v_pins,
  output logic cmp_hi
);
  import adc_ctrl_pkg::*;
  logic [9:0] held_q;
  // track the chosen input while sampling, hold it afterwards
  always_ff @(posedge clk) begin
    if (afe.sample)
      held_q <= (afe.use_vref_pins_pos | afe.use_vref_pins_neg) ? v_pins : v_rail;
  end
  // keep the trial bit while the held level reaches the code
  assign cmp_hi = held_q >= afe.dac_code;
endmodule
`default_nettype wire

// *** verif/adc_conversion_control_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_bench;
  import adc_ctrl_pkg::*;
  typedef struct packed {
    logic [9:0] vr;
    logic [9:0] vp;
    logic [7:0] c1;
    logic [7:0] hi;
    logic [7:0] lo;
    logic slp;
  } row_t;
  row_t rows [6] = '{
    '{10'h3FF, 10'h000, 8'h08, 8'h03, 8'hFF, 1'b0},
    '{10'h3FF, 10'h000, 8'h00, 8'hFF, 8'hC0, 1'b0},
    '{10'h2A5, 10'h000, 8'h00, 8'hA9, 8'h40, 1'b0},
    '{10'h000, 10'h3FF, 8'h08, 8'h00, 8'h00, 1'b0},
    '{10'h155, 10'h0F0, 8'h0B, 8'h00, 8'hF0, 1'b0},
    '{10'h2A5, 10'h000, 8'h0C, 8'h02, 8'hA5, 1'b1}};
  logic clk = 0, nrst = 0, por = 1, slp = 0, rc = 0, wr = 0, rd = 0, ce = 1, cmp, busy;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00, rdat, pins;
  logic [9:0] vr = 10'h000, vp = 10'h000;
  afe_ctrl_t afe;
  int fail_count = 0, check_count = 0, cyc = 0;
  // system clock and a free-running internal RC oscillator
  always #25 clk = ~clk;
  always #137 rc = ~rc;
  adc_conversion_control DUT (.CLK_SYS(clk), .NRST(nrst), .CE(ce), .POR_EVENT(por),
    .SLEEP(slp), .RC_TICK(rc), .ADDR(addr), .WDATA(wd), .WR(wr), .RD(rd), .RDATA(rdat),
    .CMP_HI(cmp), .AFE(afe), .PIN_ANALOG_EN(pins), .BUSY(busy));
  analog_src_model src (.clk(clk), .afe(afe), .v_rail(vr), .v_pins(vp), .cmp_hi(cmp));
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(n, e, rdat);
  endtask
  // one full conversion, completion bits, flag clear and result pair
  task automatic conv(input logic [7:0] hi, input logic [7:0] lo);
    wr_reg(4'h0, 8'h03);
    // busy only shows from the second edge after the write
    repeat (2) @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
    rd_chk(4'h0, 8'h01, "ctrl0");
    rd_chk(4'h5, 8'h01, "status");
    wr_reg(4'h5, 8'h01);
    rd_chk(4'h5, 8'h00, "status");
    rd_chk(4'h3, hi, "res_hi");
    rd_chk(4'h4, lo, "res_lo");
  endtask
  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      test_done;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    por <= 1'b0;
    foreach (rows[i]) begin
      vr <= rows[i].vr;
      vp <= rows[i].vp;
      slp <= rows[i].slp;
      wr_reg(4'h1, rows[i].c1);
      conv(rows[i].hi, rows[i].lo);
    end
    slp <= 1'b0;
    rd_chk(4'hF, 8'h00, "unmapped");
    wr_reg(4'h2, 8'h5A);
    rd_chk(4'h2, 8'h5A, "ctrl2");
    chk("pins", 8'h5A, pins);
    // reset in mid-conversion
    vr <= 10'h111;
    wr_reg(4'h0, 8'h03);
    repeat (50) @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1 chk("busy", 8'h00, {7'h00, busy});
    rd_chk(4'h0, 8'h00, "ctrl0");
    rd_chk(4'h1, 8'h00, "ctrl1");
    rd_chk(4'h2, 8'hFF, "ctrl2");
    rd_chk(4'h5, 8'h00, "status");
    rd_chk(4'h3, 8'h02, "res_hi");
    // result load held off while the power-on event stands
    por <= 1'b1;
    conv(8'h02, 8'hA5);
    por <= 1'b0;
    // switching off aborts without a flag
    wr_reg(4'h0, 8'h03);
    repeat (30) @(posedge clk);
    wr_reg(4'h0, 8'h00);
    repeat (3) @(posedge clk);
    chk("busy", 8'h00, {7'h00, busy});
    rd_chk(4'h5, 8'h00, "status");
    // clock enable low freezes a running conversion, which then finishes
    wr_reg(4'h0, 8'h03);
    repeat (3) @(posedge clk);
    ce <= 1'b0;
    repeat (400) @(posedge clk);
    #1 chk("busy_frozen", 8'h01, {7'h00, busy});
    ce <= 1'b1;
    while (busy !== 1'b0) @(posedge clk);
    rd_chk(4'h5, 8'h01, "status");
    test_done;
  end
endmodule
`default_nettype wire
